//--- include/dsam_pkg.sv
// constants of the dual alarm monitor: register map, control fields,
// source codes. assumes 16-bit registers written a byte at a time.
// Summary of operation
// RULE1: two alarm channels run independently, each with its own level, polarity and source.
// RULE2: in static mode a channel compares its source value with its 16-bit threshold.
// RULE3: a threshold is read in the same number format as the selected source.
// RULE4: in dynamic mode a channel compares the change over N samples with its threshold.
// RULE5: only the low byte of a sample count is used, and counts 0 and 1 both mean one sample.
// RULE6: the dynamic window spans N ticks of the internal sample rate.
// RULE7: control bits 15..12 pick alarm two's source, code 0 switching it off.
// RULE8: control bits 11..8 pick alarm one's source with the same codes.
// RULE9: control bits 7 and 6 pick dynamic mode for alarms two and one.
// RULE10: control bits 5 and 4 make alarms two and one trip above, else below, the level.
// RULE11: control bit 3 makes both alarms watch filtered rather than raw data.
// RULE12: control bit 2 lets alarms drive the indicator line, else it is left undriven.
// RULE13: control bit 1 makes the indicator active high, else active low.
// RULE14: control bit 0 puts the indicator on line b, else on line a.
// RULE15: two status flags, one per channel, show which alarms are active.
// RULE16: the host writes each 16-bit register as two byte writes.
// RULE17: an unassigned source code switches that alarm off.
package dsam_pkg;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 7;
    localparam int NUM_CH = 2;
    localparam int NUM_SRC = 13;
    localparam int SRC_W = 4;
    localparam int COUNT_W = 8;
    localparam int HIST_DEPTH = 256;
    localparam logic [ADDR_W-1:0] ADDR_THRESH [NUM_CH] = '{7'h40, 7'h42};
    localparam logic [ADDR_W-1:0] ADDR_COUNT [NUM_CH] = '{7'h44, 7'h46};
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 7'h48;
    localparam logic [DATA_W-1:0] RESET_WORD = 16'h0000;
    // control field positions; channel 1's source field sits SRC_W above channel 0's, its mode and polarity bits one above
    localparam int CTRL_SRC_LSB = 8;
    localparam int CTRL_DYN_LSB = 6;
    localparam int CTRL_POL_LSB = 4;
    localparam int CTRL_FILT = 3;
    localparam int CTRL_IND_EN = 2;
    localparam int CTRL_IND_POL = 1;
    localparam int CTRL_IND_SEL = 0;
    typedef enum logic [SRC_W-1:0] {
        DSAM_SRC_OFF = 4'h0, DSAM_SRC_X_RATE = 4'h1,
        DSAM_SRC_Y_RATE = 4'h2, DSAM_SRC_Z_RATE = 4'h3,
        DSAM_SRC_X_ACC = 4'h4, DSAM_SRC_Y_ACC = 4'h5,
        DSAM_SRC_Z_ACC = 4'h6, DSAM_SRC_X_MAG = 4'h7,
        DSAM_SRC_GAP = 4'h8, DSAM_SRC_Y_MAG = 4'h9,
        DSAM_SRC_Z_MAG = 4'ha, DSAM_SRC_PRESS = 4'hb,
        DSAM_SRC_TEMP = 4'hc
    } dsam_src_t;
    // per code: 1 when that output is unsigned; all are twos complement
    localparam logic [NUM_SRC-1:0] SRC_UNSIGNED = 13'h0000;

    function automatic logic dsam_src_valid(input logic [SRC_W-1:0] code);
        return code != DSAM_SRC_OFF && code != DSAM_SRC_GAP &&
            code <= DSAM_SRC_TEMP;
    endfunction : dsam_src_valid
endpackage : dsam_pkg

//--- include/dsam_chan_if.sv
// carrier between the monitor top and one alarm channel engine
// assumes all members live on i_core_clk
`timescale 1ns/1ps
interface dsam_chan_if;
    import dsam_pkg::*;
    logic enable;
    logic dynamic;
    logic above;
    logic is_unsigned;
    logic tick;
    logic old_ok;
    logic trip;
    logic [DATA_W-1:0] threshold;
    logic [DATA_W-1:0] now_val;
    logic [DATA_W-1:0] old_val;
    modport ctrl (output enable, dynamic, above, is_unsigned, tick,
        old_ok, threshold, now_val, old_val, input trip);
    modport chan (input enable, dynamic, above, is_unsigned, tick,
        old_ok, threshold, now_val, old_val, output trip);
endinterface : dsam_chan_if

//--- src/dsam_history.sv
// sample history of one channel: ring of flip-flops, read N ticks back
// assumes i_push is a one-cycle pulse per sample on i_core_clk
`timescale 1ns/1ps
module dsam_history #(
    parameter int DEPTH = dsam_pkg::HIST_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_flush,
    input wire logic i_push,
    input wire logic [dsam_pkg::DATA_W-1:0] i_data,
    input wire logic [dsam_pkg::COUNT_W-1:0] i_count,
    output logic [dsam_pkg::DATA_W-1:0] o_old,
    output logic o_old_ok
);
    import dsam_pkg::*;
    localparam int AW = $clog2(DEPTH);
    if (DEPTH != (1 << AW) || DEPTH < (1 << COUNT_W))
        $error("dsam_history: DEPTH must be a power of two >= 256");

    logic [DATA_W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW:0] fill;
    logic [COUNT_W-1:0] span;

    // RULE5 zero and one both one sample
    assign span = (i_count == '0) ? COUNT_W'(1) : i_count;
    assign o_old = mem[wr_ptr - AW'(span)];
    // RULE6 window needs span ticks held
    assign o_old_ok = fill >= (AW + 1)'(span);

    // storage is not reset; fill tells what is trustworthy
    always_ff @(posedge i_core_clk) begin
        if (i_push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    // a new source or filter choice throws away older samples
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wr_ptr <= '0;
            fill <= '0;
        end else if (i_flush) begin
            fill <= '0;
        end else if (i_push) begin
            wr_ptr <= wr_ptr + 1'b1;
            fill <= (fill == (AW + 1)'(DEPTH)) ? fill : fill + 1'b1;
        end
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    a_flush_empties: assert property (i_flush |=> !o_old_ok) // RULE6
        else $error("history still valid after flush");
    a_one_sample_ok: assert property ( // RULE5
        !i_flush && i_push && i_count <= COUNT_W'(1) |=> o_old_ok)
        else $error("count 0 or 1 not served after one sample");
endmodule : dsam_history

//--- src/dsam_channel.sv
// one alarm engine: static level or rate-of-change compare per tick
// assumes now/old values are stable across the tick cycle
`timescale 1ns/1ps
module dsam_channel (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    dsam_chan_if.chan bus
);
    import dsam_pkg::*;
    localparam int EW = DATA_W + 2;

    logic signed [EW-1:0] now_s, old_s, thr_s, delta, mag, quant;
    logic hi_bit, next_trip;

    // RULE3 threshold takes the source's format
    assign hi_bit = ~bus.is_unsigned;
    assign now_s = {{2{hi_bit & bus.now_val[DATA_W-1]}}, bus.now_val};
    assign old_s = {{2{hi_bit & bus.old_val[DATA_W-1]}}, bus.old_val};
    assign thr_s = {{2{hi_bit & bus.threshold[DATA_W-1]}}, bus.threshold};
    // RULE4 magnitude of change over window
    assign delta = now_s - old_s;
    assign mag = delta[EW-1] ? -delta : delta;
    // RULE2 static compares value itself
    assign quant = bus.dynamic ? mag : now_s;
    // RULE10 above or below the level
    assign next_trip = (bus.dynamic ? bus.old_ok : 1'b1) &
        (bus.above ? (quant > thr_s) : (quant < thr_s));

    // RULE1 flag held between ticks, cleared at once when off
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            bus.trip <= 1'b0;
        end else if (!bus.enable) begin
            bus.trip <= 1'b0;
        end else if (bus.tick) begin
            bus.trip <= next_trip;
        end
    end

    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    a_static_above: assert property ( // RULE2
        bus.tick && bus.enable && !bus.dynamic && bus.above &&
        now_s > thr_s |=> bus.trip)
        else $error("static above threshold did not trip");
    a_dyn_below: assert property ( // RULE4
        bus.tick && bus.enable && bus.dynamic && !bus.above &&
        bus.old_ok && mag >= thr_s |=> !bus.trip)
        else $error("dynamic below tripped on large change");
    a_dyn_waits: assert property ( // RULE6
        bus.tick && bus.dynamic && !bus.old_ok |=> !bus.trip)
        else $error("dynamic tripped before window filled");
    a_flag_holds: assert property ( // RULE1
        !bus.tick && bus.enable |=> $stable(bus.trip))
        else $error("flag moved between ticks");
endmodule : dsam_channel

//--- src/dsam_monitor.sv
// dual threshold alarm monitor: registers, source select, indicator
// assumes byte writes from the serial engine and a sample tick pulse,
// all on i_core_clk; sensor words are held between ticks
`timescale 1ns/1ps
module dsam_monitor #(
    parameter int HIST_DEPTH = dsam_pkg::HIST_DEPTH
) (
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [dsam_pkg::ADDR_W-1:0] i_reg_addr,
    input wire logic [dsam_pkg::BYTE_W-1:0] i_reg_wdata,
    output logic [dsam_pkg::DATA_W-1:0] o_reg_rdata,
    input wire logic i_sample_tick,
    input wire logic [dsam_pkg::NUM_SRC-1:0][dsam_pkg::DATA_W-1:0]
        i_unfilt_data,
    input wire logic [dsam_pkg::NUM_SRC-1:0][dsam_pkg::DATA_W-1:0]
        i_filt_data,
    output logic [dsam_pkg::NUM_CH-1:0] o_diag_alarm,
    output logic o_dio_a,
    output logic o_dio_a_oe,
    output logic o_dio_b,
    output logic o_dio_b_oe
);
    import dsam_pkg::*;
    localparam int WAW = ADDR_W - 1;

    if (HIST_DEPTH < (1 << COUNT_W))
        $error("dsam_monitor: HIST_DEPTH too small for 8-bit counts");

    logic [DATA_W-1:0] ctrl;
    logic [DATA_W-1:0] next_ctrl;
    logic [DATA_W-1:0] thresh [NUM_CH];
    logic [COUNT_W-1:0] count [NUM_CH];
    logic [NUM_CH-1:0] flag;
    logic [NUM_CH-1:0] src_ok;
    logic [WAW-1:0] word_addr;
    logic hi_byte;
    logic wr_ctrl;
    logic [DATA_W-1:0] rd_word;

    // byte address split: even byte is low half, odd byte high half
    assign word_addr = i_reg_addr[ADDR_W-1:1];
    assign hi_byte = i_reg_addr[0];
    assign wr_ctrl = i_reg_wr && word_addr == ADDR_CTRL[ADDR_W-1:1];

    // RULE16 each byte write lands in its own half
    assign next_ctrl = hi_byte ? {i_reg_wdata, ctrl[BYTE_W-1:0]}
                               : {ctrl[DATA_W-1:BYTE_W], i_reg_wdata};

    // control word; the high byte alone retargets both sources
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl <= RESET_WORD;
        end else if (wr_ctrl) begin
            ctrl <= next_ctrl;
        end
    end

    // RULE1 two identical channels, independent settings
    for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
        dsam_chan_if chif ();
        logic [SRC_W-1:0] src;
        logic [SRC_W-1:0] src_idx;
        logic [DATA_W-1:0] sel_val;
        logic [DATA_W-1:0] next_thresh;
        logic wr_thr;
        logic wr_cnt;

        // RULE7 alarm two source field
        // RULE8 alarm one source field, same codes
        assign src = ctrl[CTRL_SRC_LSB + SRC_W * c +: SRC_W];
        // RULE17 unassigned codes act as off
        assign src_ok[c] = dsam_src_valid(src);
        assign src_idx = src_ok[c] ? src : SRC_W'(DSAM_SRC_OFF);
        // RULE11 one filter choice for both channels
        assign sel_val = ctrl[CTRL_FILT] ? i_filt_data[src_idx]
                                         : i_unfilt_data[src_idx];

        assign wr_thr = i_reg_wr &&
            word_addr == ADDR_THRESH[c][ADDR_W-1:1];
        assign wr_cnt = i_reg_wr && !hi_byte &&
            word_addr == ADDR_COUNT[c][ADDR_W-1:1];
        // RULE16 threshold built from two byte writes
        assign next_thresh = hi_byte
            ? {i_reg_wdata, thresh[c][BYTE_W-1:0]}
            : {thresh[c][DATA_W-1:BYTE_W], i_reg_wdata};

        // RULE2 full 16-bit level per channel
        always_ff @(posedge i_core_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                thresh[c] <= RESET_WORD;
            end else if (wr_thr) begin
                thresh[c] <= next_thresh;
            end
        end

        // RULE5 high byte of the count is dropped
        always_ff @(posedge i_core_clk or negedge i_arst_n) begin
            if (!i_arst_n) begin
                count[c] <= RESET_WORD[COUNT_W-1:0];
            end else if (wr_cnt) begin
                count[c] <= i_reg_wdata;
            end
        end

        // channel settings; RULE9 mode bit, RULE10 polarity bit
        assign chif.enable = src_ok[c];
        assign chif.dynamic = ctrl[CTRL_DYN_LSB + c];
        assign chif.above = ctrl[CTRL_POL_LSB + c];
        assign chif.is_unsigned = SRC_UNSIGNED[src_idx];
        assign chif.threshold = thresh[c];
        assign chif.now_val = sel_val;
        // RULE6 one history step per sample tick
        assign chif.tick = i_sample_tick;
        assign flag[c] = chif.trip;

        // a control write may change source or filter, so restart
        dsam_history #(
            .DEPTH(HIST_DEPTH)
        ) u_hist (
            .i_core_clk(i_core_clk),
            .i_arst_n(i_arst_n),
            .i_flush(wr_ctrl),
            .i_push(i_sample_tick),
            .i_data(sel_val),
            .i_count(count[c]),
            .o_old(chif.old_val),
            .o_old_ok(chif.old_ok)
        );

        dsam_channel u_chan (
            .i_core_clk(i_core_clk),
            .i_arst_n(i_arst_n),
            .bus(chif)
        );
    end : g_ch

    // RULE15 one status flag per channel, straight from its register
    assign o_diag_alarm = flag;

    // indicator drive terms; idle line shows the inactive level
    logic alarm_any;
    logic ind_level;
    logic ind_on_a;
    logic ind_on_b;
    assign alarm_any = |flag;
    // RULE13 active level picks the drive polarity
    assign ind_level = alarm_any ? ctrl[CTRL_IND_POL]
                                 : ~ctrl[CTRL_IND_POL];
    // RULE12 enable gates any drive
    // RULE14 line select
    assign ind_on_a = ctrl[CTRL_IND_EN] & ~ctrl[CTRL_IND_SEL];
    assign ind_on_b = ctrl[CTRL_IND_EN] & ctrl[CTRL_IND_SEL];

    // registered pins so both lines switch glitch free
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_dio_a <= 1'b0;
            o_dio_a_oe <= 1'b0;
            o_dio_b <= 1'b0;
            o_dio_b_oe <= 1'b0;
        end else begin
            o_dio_a <= ind_on_a & ind_level;
            o_dio_a_oe <= ind_on_a;
            o_dio_b <= ind_on_b & ind_level;
            o_dio_b_oe <= ind_on_b;
        end
    end

    // read decode; unused count bits and unmapped words read as zero
    assign rd_word =
        (word_addr == ADDR_CTRL[ADDR_W-1:1]) ? ctrl :
        (word_addr == ADDR_THRESH[0][ADDR_W-1:1]) ? thresh[0] :
        (word_addr == ADDR_THRESH[1][ADDR_W-1:1]) ? thresh[1] :
        (word_addr == ADDR_COUNT[0][ADDR_W-1:1])
            ? {{(DATA_W - COUNT_W){1'b0}}, count[0]} :
        (word_addr == ADDR_COUNT[1][ADDR_W-1:1])
            ? {{(DATA_W - COUNT_W){1'b0}}, count[1]} :
        RESET_WORD;

    // read data holds until the next read strobe
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_reg_rdata <= RESET_WORD;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rd_word;
        end
    end

    // checks on the register file, selection and indicator
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    a_count_low_only: assert property ( // RULE5
        i_reg_wr && hi_byte && word_addr == ADDR_COUNT[0][ADDR_W-1:1]
        |=> $stable(count[0]))
        else $error("count high byte changed the count");

    a_thresh_two_bytes: assert property ( // RULE16
        i_reg_wr && !hi_byte && word_addr == ADDR_THRESH[1][ADDR_W-1:1]
        |=> thresh[1][BYTE_W-1:0] == $past(i_reg_wdata) &&
            thresh[1][DATA_W-1:BYTE_W] ==
            $past(thresh[1][DATA_W-1:BYTE_W]))
        else $error("low byte write touched the high byte");

    a_ctrl_readback: assert property ( // RULE9
        i_reg_rd && !i_reg_wr && word_addr == ADDR_CTRL[ADDR_W-1:1]
        |=> o_reg_rdata == ctrl)
        else $error("control read back wrong");

    a_bad_src_off: assert property ( // RULE17
        !src_ok[1] |=> !o_diag_alarm[1])
        else $error("alarm two active with unassigned source");

    a_src_two_sel: assert property ( // RULE7
        ctrl[CTRL_SRC_LSB + SRC_W +: SRC_W] == SRC_W'(DSAM_SRC_Z_RATE)
        && !ctrl[CTRL_FILT] |-> g_ch[1].sel_val == i_unfilt_data[3])
        else $error("alarm two source select wrong");

    a_filter_sel: assert property ( // RULE11
        ctrl[CTRL_FILT] && src_ok[0] |->
        g_ch[0].sel_val == i_filt_data[g_ch[0].src])
        else $error("filtered data not selected");

    a_ind_disabled: assert property ( // RULE12
        !ctrl[CTRL_IND_EN] |=> !o_dio_a_oe && !o_dio_b_oe)
        else $error("indicator driven while disabled");

    a_ind_active_low: assert property ( // RULE13
        ctrl[CTRL_IND_EN] && !ctrl[CTRL_IND_POL] && |o_diag_alarm
        && $stable(ctrl) |=> (o_dio_a_oe && !o_dio_a) ||
        (o_dio_b_oe && !o_dio_b))
        else $error("active low indicator not low");

    a_ind_route_b: assert property ( // RULE14
        ctrl[CTRL_IND_EN] && ctrl[CTRL_IND_SEL] |=>
        o_dio_b_oe && !o_dio_a_oe && o_dio_b == $past(ind_level))
        else $error("indicator not on line b");

    a_diag_follows: assert property ( // RULE15
        !src_ok[0] [*2] |-> !o_diag_alarm[0] [*2])
        else $error("status flag set for disabled alarm one");

    c_static_trip: cover property (
        !ctrl[CTRL_DYN_LSB] && $rose(o_diag_alarm[0]));
    c_dynamic_trip: cover property (
        ctrl[CTRL_DYN_LSB + 1] && $rose(o_diag_alarm[1]));
    c_line_b_alarm: cover property (o_dio_b_oe && o_dio_b);
    c_alarm_clears: cover property ($fell(o_diag_alarm[0]));
endmodule : dsam_monitor

//--- test/dsam_host_model.sv
// host side of the alarm monitor: byte writes, word reads, sample ticks
// and the sensor words. assumes its tasks are called after a falling
// edge of i_core_clk, so every change lands half a period off the edge
`timescale 1ns/1ps
module dsam_host_model (
    input wire logic i_core_clk,
    input wire logic [dsam_pkg::DATA_W-1:0] i_reg_rdata,
    output logic o_reg_wr,
    output logic o_reg_rd,
    output logic [dsam_pkg::ADDR_W-1:0] o_reg_addr,
    output logic [dsam_pkg::BYTE_W-1:0] o_reg_wdata,
    output logic o_sample_tick,
    output logic [dsam_pkg::NUM_SRC-1:0][dsam_pkg::DATA_W-1:0] o_unfilt,
    output logic [dsam_pkg::NUM_SRC-1:0][dsam_pkg::DATA_W-1:0] o_filt
);
    import dsam_pkg::*;

    // everything idle and zero from time zero
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 7'h00;
        o_reg_wdata = 8'h00;
        o_sample_tick = 1'b0;
        o_unfilt = '0;
        o_filt = '0;
    end

    // strobe held across one rising edge; released bus shows junk so a
    // design that samples late cannot see the old byte
    task automatic wr_byte(input logic [ADDR_W-1:0] addr,
        input logic [BYTE_W-1:0] data);
        @(negedge i_core_clk);
        o_reg_wr = 1'b1;
        o_reg_addr = addr;
        o_reg_wdata = data;
        @(negedge i_core_clk);
        o_reg_wr = 1'b0;
        o_reg_wdata = ~data;
    endtask : wr_byte

    task automatic wr_word(input logic [ADDR_W-1:0] addr,
        input logic [DATA_W-1:0] data);
        wr_byte(addr, data[7:0]);
        wr_byte(addr | 7'h01, data[15:8]);
    endtask : wr_word

    // read word is taken a cycle and a half after the rising edge that samples the strobe
    task automatic rd_word(input logic [ADDR_W-1:0] addr,
        output logic [DATA_W-1:0] data);
        @(negedge i_core_clk);
        o_reg_rd = 1'b1;
        o_reg_addr = addr;
        @(negedge i_core_clk);
        o_reg_rd = 1'b0;
        @(negedge i_core_clk);
        data = i_reg_rdata;
    endtask : rd_word

    // one tick, then three cycles so both flag and pins have landed
    task automatic sample();
        @(negedge i_core_clk);
        o_sample_tick = 1'b1;
        @(negedge i_core_clk);
        o_sample_tick = 1'b0;
        repeat (3) @(negedge i_core_clk);
    endtask : sample

    task automatic put(input int code, input logic [DATA_W-1:0] raw,
        input logic [DATA_W-1:0] flt);
        o_unfilt[code] = raw;
        o_filt[code] = flt;
    endtask : put
endmodule : dsam_host_model

//--- test/testbench.sv
// self-checking bench of the dual alarm monitor: registers, static and
// dynamic alarms, source codes, filtering and the indicator pins.
// assumes the host model above drives every input of the monitor except clock and reset
`timescale 1ns/1ps
module testbench;
    import dsam_pkg::*;
    logic clk;
    logic arst_n;
    logic reg_wr, reg_rd, tick;
    logic [ADDR_W-1:0] reg_addr;
    logic [BYTE_W-1:0] reg_wdata;
    logic [DATA_W-1:0] reg_rdata, rd;
    logic [NUM_SRC-1:0][DATA_W-1:0] unfilt, filt;
    logic [NUM_CH-1:0] diag;
    logic dio_a, dio_a_oe, dio_b, dio_b_oe;
    logic [15:0] ctrl;
    logic [1:0] e2;
    logic lvl;
    int failures = 0;
    int n_checks = 0;
    int nn;
    // static cases: z accel vs 0x0348 below, z rate vs -1000 above
    logic [15:0] s_acc [5] = '{16'h0347, 16'h0348, 16'h8000, 16'h7fff,
        16'h0000};
    logic [15:0] s_rate [5] = '{16'hfc19, 16'hfc18, 16'h7fff, 16'h8000,
        16'h8000};
    logic [1:0] s_exp [5] = '{2'b11, 2'b00, 2'b11, 2'b00, 2'b01};
    logic [7:0] d_cnt [3] = '{8'h00, 8'h01, 8'h03};

    dsam_monitor i_dut (.i_core_clk(clk), .i_arst_n(arst_n),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
        .i_sample_tick(tick), .i_unfilt_data(unfilt), .i_filt_data(filt),
        .o_diag_alarm(diag), .o_dio_a(dio_a), .o_dio_a_oe(dio_a_oe),
        .o_dio_b(dio_b), .o_dio_b_oe(dio_b_oe));

    dsam_host_model i_host (.i_core_clk(clk), .i_reg_rdata(reg_rdata),
        .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata), .o_sample_tick(tick),
        .o_unfilt(unfilt), .o_filt(filt));

    // 40 MHz core clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_reg(input logic [ADDR_W-1:0] a,
        input logic [15:0] exp);
        i_host.rd_word(a, rd);
        chk("register word", exp, rd);
    endtask : chk_reg

    task automatic test_done();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end

    initial begin
        arst_n = 1'b0;
        repeat (12) @(negedge clk);
        arst_n = 1'b1;
        // reset words, an unmapped word, then write and read back
        for (int a = 8'h40; a <= 8'h4a; a += 2) begin
            chk_reg(7'(a), 16'h0000);
        end
        rd = 16'({diag, dio_a, dio_a_oe, dio_b, dio_b_oe});
        chk("pins after reset", 16'h0000, rd);
        i_host.wr_word(ADDR_THRESH[0], 16'h0348);
        chk_reg(ADDR_THRESH[0], 16'h0348);
        i_host.wr_word(ADDR_COUNT[0], 16'hab12);
        chk_reg(ADDR_COUNT[0], 16'h0012);
        $display("test registers done");
        // static levels, signed, strict, channels side by side
        i_host.wr_word(ADDR_THRESH[1], 16'hfc18);
        i_host.wr_word(ADDR_CTRL, 16'h3620);
        for (int i = 0; i < 5; i++) begin
            i_host.put(6, s_acc[i], ~s_acc[i]);
            i_host.put(3, s_rate[i], ~s_rate[i]);
            i_host.sample();
            chk("static flags", {14'h0, s_exp[i]}, {14'h0, diag});
        end
        $display("test static done");
        // filtered words chosen by one shared bit
        i_host.put(6, 16'h0000, 16'h0400);
        for (int f = 0; f < 2; f++) begin
            i_host.wr_word(ADDR_CTRL, 16'h0600 | 16'(f << 3));
            i_host.sample();
            chk("filter flags", 16'(f == 0), {14'h0, diag});
        end
        $display("test filter done");
        // indicator enable, level and line, alarm off then on
        for (int a = 0; a < 2; a++) begin
            i_host.put(6, a ? 16'h0000 : 16'h0400, a ? 16'h0 : 16'h0400);
            for (int k = 0; k < 8; k++) begin
                i_host.wr_word(ADDR_CTRL, 16'h0600 | 16'(k));
                i_host.sample();
                lvl = a[0] ? k[1] : ~k[1];
                e2 = {k[2] & k[0], k[2] & ~k[0]};
                chk("indicator pins", {12'h0, e2[1] & lvl, e2[1],
                    e2[0] & lvl, e2[0]}, {12'h0, dio_b, dio_b_oe, dio_a,
                    dio_a_oe});
            end
        end
        $display("test indicator done");
        // every source code on each channel; only the chosen word trips
        i_host.wr_word(ADDR_THRESH[0], 16'h0000);
        i_host.wr_word(ADDR_THRESH[1], 16'h0000);
        for (int s = 0; s < NUM_SRC; s++) begin
            i_host.put(s, 16'hfff0, 16'hfff0);
        end
        for (int ch = 0; ch < 2; ch++) begin
            for (int c = 0; c < 16; c++) begin
                if (c < NUM_SRC) i_host.put(c, 16'h0010, 16'h0010);
                ctrl = 16'h0000;
                ctrl[CTRL_SRC_LSB + 4 * ch +: 4] = 4'(c);
                ctrl[CTRL_POL_LSB + ch] = 1'b1;
                i_host.wr_word(ADDR_CTRL, ctrl);
                i_host.sample();
                // only the channel under test may trip
                e2 = 2'b00;
                e2[ch] = (c != 0 && c != 8 && c <= 12);
                chk("source flags", {14'h0, e2}, {14'h0, diag});
                if (c < NUM_SRC) i_host.put(c, 16'hfff0, 16'hfff0);
            end
        end
        $display("test sources done");
        // dynamic alarm two: change over N ticks above 100
        i_host.wr_word(ADDR_THRESH[1], 16'h0064);
        for (int i = 0; i < 3; i++) begin
            nn = (d_cnt[i] < 2) ? 1 : int'(d_cnt[i]);
            i_host.wr_word(ADDR_COUNT[1], {8'h55, d_cnt[i]});
            chk_reg(ADDR_COUNT[1], {8'h00, d_cnt[i]});
            i_host.wr_word(ADDR_CTRL, 16'h30a0);
            i_host.put(3, 16'h0000, 16'h0000);
            repeat (nn + 1) i_host.sample();
            chk("dyn settled", 16'h0000, {14'h0, diag});
            i_host.put(3, 16'h00c8, 16'h00c8);
            for (int t = 0; t < nn; t++) begin
                i_host.sample();
                chk("dyn step", 16'h0002, {14'h0, diag});
            end
            i_host.sample();
            chk("dyn window end", 16'h0000, {14'h0, diag});
        end
        $display("test dynamic done");
        // dynamic alarm one, below 100 over two samples
        i_host.wr_word(ADDR_THRESH[0], 16'h0064);
        i_host.wr_word(ADDR_COUNT[0], 16'h0002);
        i_host.wr_word(ADDR_CTRL, 16'h0640);
        i_host.put(6, 16'h0000, 16'h0000);
        repeat (2) i_host.sample();
        chk("dyn below waits", 16'h0000, {14'h0, diag});
        i_host.sample();
        chk("dyn below still", 16'h0001, {14'h0, diag});
        i_host.put(6, 16'h00c8, 16'h00c8);
        repeat (2) i_host.sample();
        chk("dyn below moved", 16'h0000, {14'h0, diag});
        i_host.sample();
        chk("dyn below again", 16'h0001, {14'h0, diag});
        $display("test dynamic below done");
        test_done();
    end
endmodule : testbench
